// file: fpu_move_chk_asserts.sv
// concurrent checks on the float move block ports
`timescale 1ns/100ps
module fpu_move_chk (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire fpu_move_pkg::instr_t instr_in, // instruction
    input wire logic copy_req, // copy request
    input wire logic [2:0] copy_sel, // copy source
    input wire logic producer_valid, // producer issued
    input wire logic [2:0] producer_sel, // producer dest
    input wire logic producer_two_cycle, // two-cycle producer
    input wire logic copy_stall, // copy held
    input wire logic copy_done, // copy written
    input wire logic [31:0] cpu_temp_reg, // temp register
    input wire fpu_move_pkg::mem_write_t mem_write, // copy write
    input wire fpu_move_pkg::float_status_t float_status_register // flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic lc_hit;
    logic [31:0] wd;
    assign lc_hit = instr_in.valid && instr_in.first_word == fpu_move_pkg::LOAD_COPY_WORD
        && instr_in.second_word[15:11] == 5'h00;
    assign wd = mem_write.data;
    property p_done; copy_done |-> $past(copy_req); endproperty
    a_done: assert property (p_done) else $error("copy done without request");
    property p_gap1; producer_valid && !producer_two_cycle ##1 copy_req && copy_sel == $past(producer_sel)
        |=> copy_stall && !copy_done; endproperty
    a_gap1: assert property (p_gap1) else $error("copy not held after single producer");
    property p_gap2; producer_valid && producer_two_cycle ##2 copy_req && copy_sel == $past(producer_sel, 2)
        |=> copy_stall; endproperty
    a_gap2: assert property (p_gap2) else $error("copy not held after two-cycle producer");
    property p_wr; mem_write.valid |-> $past(lc_hit) && mem_write.addr == $past(instr_in.mem_addr) + 32'h2
        && wd == $past(instr_in.mem_data); endproperty
    a_wr: assert property (p_wr) else $error("bad copy write");
    property p_dec; lc_hit |=> mem_write.valid; endproperty
    a_dec: assert property (p_dec) else $error("load-with-copy not done in one cycle");
    property p_ff; mem_write.valid |-> float_status_register.float_negative_flag == (wd[31] && wd[30:23] != 8'h00)
        && float_status_register.float_zero_flag == (wd[30:23] == 8'h00); endproperty
    a_ff: assert property (p_ff) else $error("float flags wrong");
    property p_if; mem_write.valid |-> float_status_register.integer_negative_flag == wd[31]
        && float_status_register.integer_zero_flag == (wd == 32'h0000_0000); endproperty
    a_if: assert property (p_if) else $error("integer flags wrong");
    property p_keep; !lc_hit |=> $stable(float_status_register); endproperty
    a_keep: assert property (p_keep) else $error("flags changed");
    property p_temp; !copy_done |-> $stable(cpu_temp_reg); endproperty
    a_temp: assert property (p_temp) else $error("temp changed without copy");
endmodule
bind fpu_register_move_load_ops fpu_move_chk chk_u (.*);

// file: fpu_move_pkg.sv
// package: opcodes, field positions, register map and carriers for the float move/load block
package fpu_move_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_COUNT = 8;
    localparam int unsigned SEL_W = 3;
    // instruction word patterns and field positions
    localparam logic [15:0] LOAD_COPY_WORD = 16'he223;
    localparam logic [12:0] UPPER_IMM_PREFIX = 13'h1d00;
    localparam logic [12:0] LOWER_IMM_PREFIX = 13'h1d01;
    localparam int unsigned PREFIX_LSB = 3;
    localparam logic [4:0] LOAD_COPY_ZERO = 5'h00;
    localparam int unsigned LOAD_COPY_ZERO_LSB = 11;
    localparam int unsigned LOAD_COPY_SEL_LSB = 8;
    localparam int unsigned MEM_FIELD_W = 8;
    localparam int unsigned IMM_LO_W = 13;
    // float register layout
    localparam int unsigned SIGN_BIT = 31;
    localparam int unsigned EXP_MSB = 30;
    localparam int unsigned EXP_LSB = 23;
    localparam int unsigned HALF_W = 16;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [7:0] EXP_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] MEM_COPY_STEP = 32'h0000_0002;
    // alignment gaps between a float producer and a copy to a cpu register
    localparam logic [1:0] GAP_SINGLE = 2'h1;
    localparam logic [1:0] GAP_DOUBLE = 2'h2;
    localparam logic [1:0] GAP_NONE = 2'h0;
    // AXI4-Lite register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_TEMP = 8'h04;
    localparam logic [7:0] ADDR_FREG0 = 8'h20;
    localparam int unsigned FREG_IDX_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic float_negative_flag;
        logic float_zero_flag;
        logic integer_negative_flag;
        logic integer_zero_flag;
    } float_status_t;

    typedef struct packed {
        logic valid;
        logic [15:0] first_word;
        logic [15:0] second_word;
        logic [31:0] mem_data;
        logic [31:0] mem_addr;
    } instr_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } mem_write_t;
endpackage

// file: fpu_register_move_load_ops.sv
// float register move and load instruction executor with AXI4-Lite visibility
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - copy-to-temporary moves all 32 bits of the chosen float register into the cpu temp register unchanged.
// - copy-to-temporary leaves every float status flag as it was.
// - a float-to-cpu copy takes one cycle but waits for pipeline alignment before reading its source.
// - after a single-cycle float producer one alignment cycle separates it from the copy.
// - after a two-cycle float producer two cycles separate it from the copy.
// - load-with-copy loads the memory word into the float register and writes it two addresses higher.
// - load-with-copy decodes from first word e223 with five zero bits, a register select and memory field.
// - load-with-copy sets float negative from bit 31 and zero clear, or zero set and negative clear on zero exponent.
// - load-with-copy sets integer negative from bit 31 and integer zero only for an all-zero word.
// - load-with-copy completes in one cycle with its destination usable at once.
// - upper-half load writes the 16-bit immediate to bits 31:16 and clears bits 15:0.
// - upper-half load decodes from prefix 1d00 plus three immediate bits and thirteen more with a select.
// - lower-half load decodes from prefix 1d01 plus three immediate bits and thirteen more with a select.
// - lower-half load writes bits 15:0, keeps bits 31:16 and changes no flags.
// - float operands select one of eight 32-bit registers by a 3-bit field.
// - a full immediate load is one upper-half load, plus a lower-half load when the low half is nonzero.
module fpu_register_move_load_ops (
    input wire logic aclk, // cpu clock
    input wire logic aresetn, // synchronous reset, active low
    input wire fpu_move_pkg::instr_t instr_in, // issued instruction with fetched memory word
    input wire logic copy_req, // request copy of a float register to the temp register
    input wire logic [2:0] copy_sel, // float register to copy
    input wire logic producer_valid, // a float instruction issued this cycle
    input wire logic [2:0] producer_sel, // its destination register
    input wire logic producer_two_cycle, // it has two pipeline cycles
    output logic copy_stall, // copy held for alignment
    output logic copy_done, // temp register written this cycle
    output logic [31:0] cpu_temp_reg, // cpu temporary register
    output fpu_move_pkg::mem_write_t mem_write, // load-with-copy write to address+2
    output fpu_move_pkg::float_status_t float_status_register, // flags
    input wire logic [7:0] s_axi_awaddr, // AXI4-Lite write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    logic [31:0] float_reg [fpu_move_pkg::REG_COUNT];
    logic [1:0] gap_reg [fpu_move_pkg::REG_COUNT];
    logic [2:0] dest_sel;
    logic is_load_copy;
    logic is_upper;
    logic is_lower;
    logic [15:0] imm_half;
    logic copy_ready;
    logic [31:0] loaded;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic sw_write;
    logic sw_write_ok;
    logic [2:0] sw_idx;

    // each half is decoded alone; a full immediate is just two back-to-back issues
    always_comb begin
        is_load_copy = instr_in.valid && instr_in.first_word == fpu_move_pkg::LOAD_COPY_WORD
            && instr_in.second_word[15:fpu_move_pkg::LOAD_COPY_ZERO_LSB]
               == fpu_move_pkg::LOAD_COPY_ZERO;
        is_upper = instr_in.valid
            && instr_in.first_word[15:fpu_move_pkg::PREFIX_LSB] == fpu_move_pkg::UPPER_IMM_PREFIX;
        is_lower = instr_in.valid
            && instr_in.first_word[15:fpu_move_pkg::PREFIX_LSB] == fpu_move_pkg::LOWER_IMM_PREFIX;
        imm_half = {instr_in.first_word[fpu_move_pkg::PREFIX_LSB-1:0],
                    instr_in.second_word[15:fpu_move_pkg::SEL_W]};
        if (is_load_copy) begin
            dest_sel = instr_in.second_word[fpu_move_pkg::LOAD_COPY_ZERO_LSB-1:fpu_move_pkg::LOAD_COPY_SEL_LSB];
        end else begin
            dest_sel = instr_in.second_word[fpu_move_pkg::SEL_W-1:0];
        end
        loaded = instr_in.mem_data;
        copy_ready = gap_reg[copy_sel] == fpu_move_pkg::GAP_NONE;
        sw_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
        sw_write_ok = aw_addr_reg >= fpu_move_pkg::ADDR_FREG0
            && aw_addr_reg[1:0] == 2'h0
            && aw_addr_reg < fpu_move_pkg::ADDR_FREG0 + 8'(fpu_move_pkg::REG_COUNT * 4);
        sw_idx = 3'(aw_addr_reg[7:fpu_move_pkg::FREG_IDX_LSB]);
    end

    // float register file; software writes only when no instruction targets the same entry
    generate
        for (genvar i = 0; i < fpu_move_pkg::REG_COUNT; i++) begin : g_freg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    float_reg[i] <= fpu_move_pkg::WORD_ZERO;
                end else if (is_load_copy && dest_sel == 3'(i)) begin
                    float_reg[i] <= loaded;
                end else if (is_upper && dest_sel == 3'(i)) begin
                    float_reg[i] <= {imm_half, fpu_move_pkg::HALF_ZERO};
                end else if (is_lower && dest_sel == 3'(i)) begin
                    float_reg[i][fpu_move_pkg::HALF_W-1:0] <= imm_half;
                end else if (sw_write && sw_write_ok && sw_idx == 3'(i)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb_reg[b]) begin
                            float_reg[i][b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        end
                    end
                end
            end

            // pending alignment cycles per register
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    gap_reg[i] <= fpu_move_pkg::GAP_NONE;
                end else if (producer_valid && producer_sel == 3'(i)) begin
                    gap_reg[i] <= producer_two_cycle ? fpu_move_pkg::GAP_DOUBLE
                                                     : fpu_move_pkg::GAP_SINGLE;
                end else if (gap_reg[i] != fpu_move_pkg::GAP_NONE) begin
                    gap_reg[i] <= gap_reg[i] - 2'h1;
                end
            end
        end
    endgenerate

    // copy to temp: one cycle once aligned, flags untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_temp_reg <= fpu_move_pkg::WORD_ZERO;
            copy_done <= 1'b0;
            copy_stall <= 1'b0;
        end else begin
            // the request still stands on the edge that shows done; do not take it twice
            copy_done <= copy_req && copy_ready && !copy_done;
            copy_stall <= copy_req && !copy_ready;
            if (copy_req && copy_ready && !copy_done) begin
                cpu_temp_reg <= float_reg[copy_sel];
            end
        end
    end

    // duplicate the loaded word two locations up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_write <= '0;
        end else begin
            mem_write.valid <= is_load_copy;
            mem_write.addr <= instr_in.mem_addr + fpu_move_pkg::MEM_COPY_STEP;
            mem_write.data <= loaded;
        end
    end

    // only load-with-copy touches flags; moves and immediates leave them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            float_status_register <= '0;
        end else if (is_load_copy) begin
            if (loaded[fpu_move_pkg::EXP_MSB:fpu_move_pkg::EXP_LSB] == fpu_move_pkg::EXP_ZERO) begin
                float_status_register.float_zero_flag <= 1'b1;
                float_status_register.float_negative_flag <= 1'b0;
            end else begin
                float_status_register.float_zero_flag <= 1'b0;
                float_status_register.float_negative_flag <= loaded[fpu_move_pkg::SIGN_BIT];
            end
            float_status_register.integer_negative_flag <= loaded[fpu_move_pkg::SIGN_BIT];
            float_status_register.integer_zero_flag <= loaded == fpu_move_pkg::WORD_ZERO;
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= fpu_move_pkg::WORD_ZERO;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fpu_move_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (sw_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= sw_write_ok ? fpu_move_pkg::RESP_OKAY : fpu_move_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read side: status, temp and the eight float registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= fpu_move_pkg::WORD_ZERO;
            s_axi_rresp <= fpu_move_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= fpu_move_pkg::RESP_OKAY;
                if (s_axi_araddr == fpu_move_pkg::ADDR_STATUS) begin
                    s_axi_rdata <= {28'h0000000, float_status_register};
                end else if (s_axi_araddr == fpu_move_pkg::ADDR_TEMP) begin
                    s_axi_rdata <= cpu_temp_reg;
                end else if (s_axi_araddr >= fpu_move_pkg::ADDR_FREG0 && s_axi_araddr[1:0] == 2'h0
                             && s_axi_araddr < fpu_move_pkg::ADDR_FREG0 + 8'(fpu_move_pkg::REG_COUNT * 4)) begin
                    s_axi_rdata <= float_reg[3'(s_axi_araddr[7:fpu_move_pkg::FREG_IDX_LSB])];
                end else begin
                    s_axi_rdata <= fpu_move_pkg::WORD_ZERO;
                    s_axi_rresp <= fpu_move_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: host_mem_model.sv
// host data memory receiving the load-with-copy duplicate word
`timescale 1ns/100ps
module host_mem_model (
    input wire logic aclk, // clock
    input wire fpu_move_pkg::mem_write_t mem_write // write from block
);
    logic [31:0] mem [256];
    // unwritten words hold a pattern so a missing write is not read as zero
    initial for (int i = 0; i < 256; i++) mem[i] = {24'ha5c3e1, 8'(i)};
    always @(posedge aclk) if (mem_write.valid) mem[mem_write.addr[7:0]] <= mem_write.data;
endmodule

// file: tb_fpu_register_move_load_ops.sv
// self-checking bench for the float move block
`timescale 1ns/100ps
module tb_fpu_register_move_load_ops;
    logic aclk = 0, aresetn = 0, copy_req = 0, producer_valid = 0, producer_two_cycle = 0;
    logic [2:0] copy_sel = 0, producer_sel = 0;
    fpu_move_pkg::instr_t instr_in = '0;
    fpu_move_pkg::mem_write_t mem_write;
    fpu_move_pkg::float_status_t float_status_register;
    logic copy_stall, copy_done, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, cpu_temp_reg;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fails = 0, tests_run = 0, cyc = 0;
    fpu_register_move_load_ops dut_u (.*);
    host_mem_model host_u (.aclk(aclk), .mem_write(mem_write));
    initial forever #25 aclk = ~aclk;
    task automatic finish_test;
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic ins(input logic [15:0] f, input logic [15:0] s, input logic [31:0] a);
        @(posedge aclk);
        instr_in <= {1'b1, f, s, host_u.mem[a[7:0]], a};
    endtask
    task automatic imm(input logic lo, input logic [15:0] v, input logic [2:0] sel);
        ins({lo ? fpu_move_pkg::LOWER_IMM_PREFIX : fpu_move_pkg::UPPER_IMM_PREFIX, v[15:13]}, {v[12:0], sel}, 0);
    endtask
    task automatic idle;
        @(posedge aclk);
        instr_in.valid <= 1'b0;
    endtask
    // cycles from raising the request to seeing done; request held until done
    task automatic cp(input logic [2:0] sel, output int n);
        @(posedge aclk);
        producer_valid <= 1'b0;
        copy_req <= 1'b1;
        copy_sel <= sel;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!copy_done && n < 20);
        copy_req <= 1'b0;
    endtask
    task automatic prod(input logic [2:0] sel, input logic two);
        @(posedge aclk);
        producer_valid <= 1'b1;
        producer_sel <= sel;
        producer_two_cycle <= two;
    endtask
    function automatic logic [31:0] fl(input logic [31:0] w);
        fl = {28'h0, w[31] && w[30:23] != 8'h00, w[30:23] == 8'h00, w[31], w == 32'h0};
    endfunction
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        logic [31:0] w [4];
        w = '{32'h4110_0000, 32'h8000_0000, 32'h0000_0000, 32'hc0b0_0000};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            imm(1'b0, 16'(16'h4049 + i), 3'(i));
            imm(1'b1, 16'(16'h0fdb - i), 3'(i));
        end
        imm(1'b0, 16'hbfc0, 3'd1);
        idle;
        for (int i = 0; i < 8; i++) begin
            rd(8'(fpu_move_pkg::ADDR_FREG0 + 4 * i), d, r);
            chk(d, i == 1 ? 32'hbfc0_0000 : {16'(16'h4049 + i), 16'(16'h0fdb - i)});
        end
        rd(fpu_move_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0);
        $display("test imm done");
        for (int k = 0; k < 4; k++) begin
            host_u.mem[8'h40 + 8 * k] = w[k];
            ins(fpu_move_pkg::LOAD_COPY_WORD, {5'h00, 3'(k), 8'(8'h40 + 8 * k)}, 32'h40 + 8 * k);
            idle;
            rd(8'(fpu_move_pkg::ADDR_FREG0 + 4 * k), d, r);
            chk(d, w[k]);
            rd(fpu_move_pkg::ADDR_STATUS, d, r);
            chk(d, fl(w[k]));
            chk(host_u.mem[8'h42 + 8 * k], w[k]);
        end
        ins(fpu_move_pkg::LOAD_COPY_WORD, {5'h01, 3'd7, 8'h40}, 32'h40);
        idle;
        rd(8'h3c, d, r);
        chk(d, 32'h4050_0fd4);
        $display("test load copy done");
        cp(3'd5, n);
        chk(n, 2);
        chk(cpu_temp_reg, 32'h404e_0fd6);
        prod(3'd7, 1'b0);
        cp(3'd7, n);
        chk(n, 3);
        prod(3'd6, 1'b1);
        cp(3'd6, n);
        chk(n, 4);
        chk(cpu_temp_reg, 32'h404f_0fd5);
        rd(fpu_move_pkg::ADDR_STATUS, d, r);
        chk(d, fl(w[3]));
        $display("test copy done");
        wr(8'h30, 32'hdead_beef, r);
        chk(32'(r), 32'(fpu_move_pkg::RESP_OKAY));
        rd(8'h30, d, r);
        chk(d, 32'hdead_beef);
        wr(fpu_move_pkg::ADDR_STATUS, 32'hf, r);
        chk(32'(r), 32'(fpu_move_pkg::RESP_SLVERR));
        rd(8'h10, d, r);
        chk({d[29:0], r}, 32'(fpu_move_pkg::RESP_SLVERR));
        $display("test bus done");
        finish_test;
    end
endmodule
